/* File: hw/vis_top.sv */
// Interrupt acceptance, mode selection and vector generation with APB registers
`timescale 1ns/1ns
module vis_top #(
  parameter int AW = 12
) (
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [5:0]    hw_irq_i,
  input  wire logic [2:0]    timer_irq_line_i,
  input  wire logic [2:0]    perfcount_irq_line_i,
  input  wire logic [2:0]    debugchan_irq_line_i,
  input  wire logic          vectored_capable_i,
  input  wire logic          external_ctrl_capable_i,
  input  wire logic          timer_evt_i,
  input  wire logic          perfcount_evt_i,
  input  wire logic          debugchan_evt_i,
  input  wire logic          inhibit_i,
  input  wire logic          exc_other_i,
  input  wire logic          eret_i,
  output logic               take_o,
  output logic      [31:0]   vector_o,
  output logic      [4:0]    exception_code_o,
  output logic      [1:0]    mode_o,
  output logic      [1:0]    sw_irq_o,
  output logic               timer_irq_o,
  output logic               perfcount_irq_o,
  output logic               debugchan_irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vis_pkg::vis_state_s s;
  vis_pkg::vis_state_s next_s;

  logic [16:0]  sync_q;
  logic [5:0]   hw;
  logic [2:0]   ti_line;
  logic [2:0]   pci_line;
  logic [2:0]   debugchan_pending_line;
  logic         vectored_capable;
  logic         external_ctrl_capable;
  logic [7:0]   pending;
  logic [7:0]   enabled;
  logic [2:0]   hi_idx;
  logic [5:0]   current_priority_level;
  logic         inhibited;
  logic         vi_cond;
  vis_pkg::vis_mode_e mode;
  logic [9:0]   spacing;
  logic [5:0]   vec_num;
  logic [15:0]  vec_off;
  logic [31:0]  base;
  logic [31:0]  entry;
  logic         accept;
  logic         wr_acc;
  logic         setup;
  logic [11:0]  addr;
  logic         mapped;
  logic [7:0]   pend_view;
  logic [31:0]  rd_val;

  generate
    if (AW < 5 || AW > 12) begin : g_bad
      $error("vis_top: address width must be 5 to 12");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // inputs synchronised
  vis_sync #(
    .W (17)
  ) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({external_ctrl_capable_i, vectored_capable_i, debugchan_irq_line_i,
                perfcount_irq_line_i, timer_irq_line_i, hw_irq_i}),
    .q_o      (sync_q)
  );

  assign hw        = sync_q[5:0];
  assign ti_line   = sync_q[8:6];
  assign pci_line  = sync_q[11:9];
  assign debugchan_pending_line = sync_q[14:12];
  assign vectored_capable      = sync_q[15];
  assign external_ctrl_capable      = sync_q[16];

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  // vectored entry conditions
  assign vi_cond = vectored_capable & s.iv & (s.vs != 5'h00);

  always_comb begin
    if (!vi_cond) begin
      mode = vis_pkg::MODE_LEGACY;
    end else if (external_ctrl_capable) begin
      mode = vis_pkg::MODE_EXT;
    end else begin
      mode = vis_pkg::MODE_VECT;
    end
  end

  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // hardware plus software sources
  assign pending   = {hw, s.swi};
  assign enabled   = pending & s.mask;
  assign current_priority_level       = s.mask[7:2];
  assign inhibited = ~s.ie | s.exl | inhibit_i;

  vis_prio #(
    .W  (8),
    .IW (3)
  ) u_prio (
    .req_i (enabled),
    .idx_o (hi_idx)
  );

  always_comb begin
    case (mode)
      vis_pkg::MODE_EXT: begin
        accept = (hw > current_priority_level) & ~inhibited;
      end
      default: begin
        accept = (|enabled) & ~inhibited;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Vector address
  // ----------------------------------------------------------------
  // supported spacing values
  always_comb begin
    case (s.vs)
      5'h01, 5'h02, 5'h04, 5'h08, 5'h10: begin
        spacing = 10'(s.vs) << vis_pkg::SPACE_SHIFT;
      end
      default: begin
        spacing = 10'h000;
      end
    endcase
  end

  always_comb begin
    case (mode)
      vis_pkg::MODE_EXT: begin
        vec_num = hw;
      end
      vis_pkg::MODE_VECT: begin
        vec_num = {3'h0, hi_idx};
      end
      default: begin
        vec_num = 6'h00;
      end
    endcase
  end

  assign vec_off = 16'(vec_num) * 16'(spacing);
  assign base    = {vis_pkg::EXCEPTION_BASE_TOP, s.exception_base, 12'h000};

  always_comb begin
    if (mode != vis_pkg::MODE_LEGACY) begin
      entry = base + vis_pkg::INT_OFF + {16'h0000, vec_off};
    end else if (s.iv) begin
      entry = base + vis_pkg::INT_OFF;
    end else begin
      entry = base + vis_pkg::GEN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // APB decode and read data
  // ----------------------------------------------------------------
  assign addr   = 12'(paddr);
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & s.pready & pwrite;
  assign mapped = (addr == vis_pkg::OFF_INTERRUPT_CONTROL) | (addr == vis_pkg::OFF_CAUSE)
                | (addr == vis_pkg::OFF_STATUS) | (addr == vis_pkg::OFF_CAPAB)
                | (addr == vis_pkg::OFF_EXCEPTION_BASE)  | (addr == vis_pkg::OFF_VECTOR);

  assign pend_view = (mode == vis_pkg::MODE_EXT) ? {s.requested_level, s.swi} : pending;

  always_comb begin
    rd_val = 32'h00000000;
    case (addr)
      vis_pkg::OFF_INTERRUPT_CONTROL: begin
        rd_val[vis_pkg::TI_LSB +: 3]   = ti_line;
        rd_val[vis_pkg::PCI_LSB +: 3]  = pci_line;
        rd_val[vis_pkg::DEBUGCHAN_PENDING_LSB +: 3] = debugchan_pending_line;
        rd_val[vis_pkg::VS_LSB +: 5]   = s.vs;
      end
      vis_pkg::OFF_CAUSE: begin
        rd_val[vis_pkg::TIP_BIT]       = s.src[0];
        rd_val[vis_pkg::PCIP_BIT]      = s.src[1];
        rd_val[vis_pkg::FDCIP_BIT]     = s.src[2];
        rd_val[vis_pkg::IV_BIT]        = s.iv;
        rd_val[vis_pkg::PEND_LSB +: 8] = pend_view;
        rd_val[vis_pkg::CODE_LSB +: 5] = s.exc_code;
      end
      vis_pkg::OFF_STATUS: begin
        rd_val[vis_pkg::MASK_LSB +: 8] = s.mask;
        rd_val[vis_pkg::EXL_BIT]       = s.exl;
        rd_val[vis_pkg::IE_BIT]        = s.ie;
      end
      vis_pkg::OFF_CAPAB: begin
        rd_val[vis_pkg::VECTORED_CAPABLE_BIT]      = vectored_capable;
        rd_val[vis_pkg::EXTERNAL_CTRL_CAPABLE_BIT]      = external_ctrl_capable;
        rd_val[1:0]                    = mode;
      end
      vis_pkg::OFF_EXCEPTION_BASE: begin
        rd_val = base;
      end
      vis_pkg::OFF_VECTOR: begin
        rd_val = s.vector;
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (ce_i) begin
      next_s.pready  = setup;
      next_s.prdata  = setup ? rd_val : s.prdata;
      next_s.pslverr = setup & ~mapped;
      next_s.mode    = mode;
      next_s.src     = {debugchan_evt_i, perfcount_evt_i, timer_evt_i};
      next_s.take    = 1'b0;

      if (wr_acc) begin
        case (addr)
          vis_pkg::OFF_INTERRUPT_CONTROL: begin
            next_s.vs = pwdata[vis_pkg::VS_LSB +: 5];
          end
          vis_pkg::OFF_CAUSE: begin
            next_s.swi = pwdata[vis_pkg::PEND_LSB +: 2];
            next_s.iv  = pwdata[vis_pkg::IV_BIT];
          end
          vis_pkg::OFF_STATUS: begin
            next_s.mask = pwdata[vis_pkg::MASK_LSB +: 8];
            next_s.exl  = pwdata[vis_pkg::EXL_BIT];
            next_s.ie   = pwdata[vis_pkg::IE_BIT];
          end
          vis_pkg::OFF_EXCEPTION_BASE: begin
            next_s.exception_base = pwdata[vis_pkg::EXCEPTION_BASE_LSB +: 18];
          end
          default: begin
            next_s.vs = s.vs;
          end
        endcase
      end

      if (eret_i) begin
        next_s.exl = 1'b0;
      end

      if ((accept || exc_other_i) && mode == vis_pkg::MODE_EXT) begin
        next_s.requested_level = hw;
      end

      if (accept) begin
        next_s.take     = 1'b1;
        next_s.vector   = entry;
        next_s.exc_code = vis_pkg::EXC_INT;
        next_s.exl      = 1'b1;
      end else if (exc_other_i) begin
        next_s.exl      = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s          <= '0;
      s.vs       <= vis_pkg::VS_RST;
      s.exception_base    <= vis_pkg::EXCEPTION_BASE_RST;
      s.exc_code <= vis_pkg::EXC_INT;
      s.mode     <= vis_pkg::MODE_LEGACY;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign take_o           = s.take;
  assign vector_o         = s.vector;
  assign exception_code_o = s.exc_code;
  assign mode_o           = s.mode;
  assign sw_irq_o         = s.swi;
  assign timer_irq_o      = s.src[0];
  assign perfcount_irq_o  = s.src[1];
  assign debugchan_irq_o  = s.src[2];

endmodule : vis_top

/* File: hw/vis_pkg.sv */
// Shared constants, register map and state types of the interrupt select block
package vis_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_INTERRUPT_CONTROL = 12'h000;
  localparam logic [11:0] OFF_CAUSE  = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_CAPAB  = 12'h00c;
  localparam logic [11:0] OFF_EXCEPTION_BASE  = 12'h010;
  localparam logic [11:0] OFF_VECTOR = 12'h014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TI_LSB    = 29;
  localparam int PCI_LSB   = 26;
  localparam int DEBUGCHAN_PENDING_LSB  = 23;
  localparam int VS_LSB    = 5;
  localparam int PEND_LSB  = 8;
  localparam int IV_BIT    = 23;
  localparam int TIP_BIT   = 30;
  localparam int PCIP_BIT  = 26;
  localparam int FDCIP_BIT = 21;
  localparam int CODE_LSB  = 2;
  localparam int MASK_LSB  = 8;
  localparam int EXL_BIT   = 1;
  localparam int IE_BIT    = 0;
  localparam int VECTORED_CAPABLE_BIT  = 5;
  localparam int EXTERNAL_CTRL_CAPABLE_BIT  = 6;
  localparam int EXCEPTION_BASE_LSB = 12;

  // ----------------------------------------------------------------
  // Reset values and fixed offsets
  // ----------------------------------------------------------------
  localparam logic [4:0]  VS_RST      = 5'h00;
  localparam logic [17:0] EXCEPTION_BASE_RST   = 18'h00000;
  localparam logic [1:0]  EXCEPTION_BASE_TOP   = 2'h2;
  localparam logic [31:0] GEN_OFF     = 32'h00000180;
  localparam logic [31:0] INT_OFF     = 32'h00000200;
  localparam logic [4:0]  EXC_INT     = 5'h00;
  localparam int          SPACE_SHIFT = 5;

  // ----------------------------------------------------------------
  // Modes and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_VECT   = 2'b01,
    MODE_EXT    = 2'b10
  } vis_mode_e;

  typedef struct packed {
    logic [4:0]  vs;
    logic        iv;
    logic [1:0]  swi;
    logic [7:0]  mask;
    logic        ie;
    logic        exl;
    logic [17:0] exception_base;
    logic [5:0]  requested_level;
    logic [2:0]  src;
    logic        take;
    logic [31:0] vector;
    logic [4:0]  exc_code;
    vis_mode_e   mode;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vis_state_s;

endpackage : vis_pkg

/* File: hw/vis_sync.sv */
// Two-flop synchroniser for a group of pin-level inputs
`timescale 1ns/1ns
module vis_sync #(
  parameter int W = 17
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vis_sync_s;

  vis_sync_s s;
  vis_sync_s next_s;

  generate
    if (W < 1) begin : g_bad
      $error("vis_sync: width must be at least 1");
    end
  endgenerate

  always_comb begin
    next_s = s;
    if (ce_i) begin
      next_s.s1 = d_i;
      next_s.s2 = s.s1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;

endmodule : vis_sync

/* File: hw/vis_prio.sv */
// Highest-numbered active request encoder
`timescale 1ns/1ns
module vis_prio #(
  parameter int W  = 8,
  parameter int IW = 3
) (
  input  wire logic [W-1:0]  req_i,
  output logic      [IW-1:0] idx_o
);

  logic [W-1:0] top;

  generate
    if ((1 << IW) < W) begin : g_bad
      $error("vis_prio: index too narrow for request width");
    end
    for (genvar i = 0; i < W; i++) begin : g_bit
      if (i == W - 1) begin : g_last
        assign top[i] = req_i[i];
      end else begin : g_rest
        assign top[i] = req_i[i] & ~(|req_i[W-1:i+1]);
      end
    end
  endgenerate

  always_comb begin
    idx_o = '0;
    for (int i = 0; i < W; i++) begin
      if (top[i]) begin
        idx_o = IW'(i);
      end
    end
  end

endmodule : vis_prio

/* File: test/vis_top_props.sv */
// Port-level assertions for the interrupt select block
`timescale 1ns/1ns
module vis_top_props (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        inhibit_i,
  input wire logic        timer_evt_i,
  input wire logic        take_o,
  input wire logic [31:0] vector_o,
  input wire logic [4:0]  exception_code_o,
  input wire logic [1:0]  mode_o,
  input wire logic        timer_irq_o
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  take_pulse_a:
    assert property (take_o |=> !take_o) else $error("take longer than one cycle");
  take_code_a:
    assert property (take_o |-> exception_code_o == 5'h00) else $error("code not interrupt");
  inhibit_block_a:
    assert property (inhibit_i |=> !take_o) else $error("take while inhibited");
  vector_hold_a:
    assert property ($changed(vector_o) |-> take_o) else $error("vector moved without take");
  legacy_entry_a:
    assert property (take_o && mode_o == 2'b00 |-> vector_o[11:0] inside {12'h180, 12'h200})
      else $error("legacy entry wrong");
  vector_align_a:
    assert property (take_o |-> vector_o[4:0] == 5'h00 && vector_o[31:30] == 2'b10)
      else $error("vector misaligned");
  mode_legal_a:
    assert property (mode_o != 2'b11) else $error("illegal mode");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held");
  error_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  timer_out_a:
    assert property (timer_evt_i |=> timer_irq_o) else $error("timer output missing");

  cover property (take_o && mode_o == 2'b01);
  cover property (take_o && mode_o == 2'b10);
  cover property (pslverr);
endmodule : vis_top_props

/* File: test/vis_irq_model.sv */
// Interrupt source side: pin levels, or one encoded request in external mode
`timescale 1ns/1ns
module vis_irq_model #(
  parameter logic [2:0] TI_LINE = 3'h7
) (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       ext_i,
  input  wire logic [5:0] req_i,
  input  wire logic       timer_irq_i,
  output logic      [5:0] hw_irq_o
);
  logic [5:0] route;
  assign route = ext_i ? 6'h00 : (6'h01 << (TI_LINE - 3'h2)) & {6{timer_irq_i}};
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hw_irq_o <= 6'h00;
    end else begin
      hw_irq_o <= req_i | route;
    end
  end
endmodule : vis_irq_model

/* File: test/vis_top_tb.sv */
// Self-checking bench for the interrupt select block
`timescale 1ns/1ns
module vis_top_tb;
  logic        mclk_i   = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h00000000;
  logic [5:0]  req      = 6'h00;
  logic        ext_cap  = 1'b0;
  logic        evt      = 1'b0;
  logic        inhibit  = 1'b0;
  logic        eret     = 1'b0;
  logic        exc      = 1'b0;
  logic        vcap     = 1'b1;
  logic [31:0] prdata, vector, rd;
  logic        pready, pslverr, take, tmr, rerr, pci, debugchan_pending;
  logic [5:0]  hw_irq;
  logic [4:0]  code;
  logic [1:0]  mode, sw_irq;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc       = 0;

  always #5 mclk_i = ~mclk_i;

  vis_irq_model i_src (.mclk_i, .resetn_i, .ext_i(mode == 2'b10), .req_i(req),
    .timer_irq_i(tmr), .hw_irq_o(hw_irq));

  vis_top i_dut (.mclk_i, .resetn_i, .ce_i(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hw_irq_i(hw_irq), .timer_irq_line_i(3'h7),
    .perfcount_irq_line_i(3'h6), .debugchan_irq_line_i(3'h5), .vectored_capable_i(vcap),
    .external_ctrl_capable_i(ext_cap), .timer_evt_i(evt), .perfcount_evt_i(evt),
    .debugchan_evt_i(evt), .inhibit_i(inhibit), .exc_other_i(exc), .eret_i(eret),
    .take_o(take), .vector_o(vector), .exception_code_o(code), .mode_o(mode),
    .sw_irq_o(sw_irq), .timer_irq_o(tmr), .perfcount_irq_o(pci), .debugchan_irq_o(debugchan_pending));

  // ------------
  // Common tasks
  // ------------
  task automatic results();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd   = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  task automatic wait_take(input logic exp_take, input logic [31:0] exp_vec);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 12 && !seen; n++) begin
      @(posedge mclk_i);
      seen = (take === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, exp_take});
    if (seen) chk(vector, exp_vec);
    if (seen) chk({27'h0, code}, 32'h0);
  endtask : wait_take

  task automatic ret_pulse();
    eret <= 1'b1;
    @(posedge mclk_i);
    eret <= 1'b0;
    @(posedge mclk_i);
  endtask : ret_pulse

  // ---------
  // Scenarios
  // ---------
  task automatic t_regs();
    apb(1'b0, vis_pkg::OFF_INTERRUPT_CONTROL, 32'h0);
    chk(rd, 32'hfa800000);
    apb(1'b1, vis_pkg::OFF_CAPAB, 32'hffffffff);
    apb(1'b0, vis_pkg::OFF_CAPAB, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("registers test done");
  endtask : t_regs

  task automatic t_legacy();
    apb(1'b1, vis_pkg::OFF_STATUS, 32'h00000001);
    apb(1'b1, vis_pkg::OFF_CAUSE, 32'h00000100);
    wait_take(1'b0, 32'h0);
    chk({30'h0, sw_irq}, 32'h1);
    apb(1'b1, vis_pkg::OFF_STATUS, 32'h00000101);
    wait_take(1'b1, 32'h80000180);
    apb(1'b1, vis_pkg::OFF_CAUSE, 32'h00800000);
    ret_pulse();
    apb(1'b1, vis_pkg::OFF_CAUSE, 32'h00800200);
    apb(1'b1, vis_pkg::OFF_STATUS, 32'h00000201);
    wait_take(1'b1, 32'h80000200);
    apb(1'b0, vis_pkg::OFF_CAPAB, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b1, vis_pkg::OFF_CAUSE, 32'h00800000);
    ret_pulse();
    $display("legacy test done");
  endtask : t_legacy

  task automatic t_vect();
    logic [4:0] vs;
    apb(1'b1, vis_pkg::OFF_STATUS, 32'h0000ff01);
    for (int i = 0; i < 5; i++) begin
      vs = 5'h01 << i;
      apb(1'b1, vis_pkg::OFF_INTERRUPT_CONTROL, {22'h0, vs, 5'h00});
      req <= 6'h24;
      wait_take(1'b1, 32'h80000200 + 32'd7 * {vs, 5'h00});
      req <= 6'h00;
      repeat (5) @(posedge mclk_i);
      ret_pulse();
    end
    evt <= 1'b1;
    wait_take(1'b1, 32'h80001000);
    evt <= 1'b0;
    repeat (5) @(posedge mclk_i);
    ret_pulse();
    apb(1'b0, vis_pkg::OFF_CAPAB, 32'h0);
    chk(rd, 32'h00000021);
    vcap <= 1'b0;
    repeat (4) @(posedge mclk_i);
    apb(1'b0, vis_pkg::OFF_CAPAB, 32'h0);
    chk(rd, 32'h00000000);
    vcap <= 1'b1;
    repeat (4) @(posedge mclk_i);
    $display("vectored test done");
  endtask : t_vect

  task automatic t_ext();
    ext_cap <= 1'b1;
    apb(1'b1, vis_pkg::OFF_INTERRUPT_CONTROL, 32'h00000020);
    apb(1'b1, vis_pkg::OFF_STATUS, 32'h00001401);
    apb(1'b0, vis_pkg::OFF_CAPAB, 32'h0);
    chk(rd, 32'h00000062);
    chk({30'h0, mode}, 32'h2);
    req <= 6'h05;
    wait_take(1'b0, 32'h0);
    inhibit <= 1'b1;
    req     <= 6'h09;
    wait_take(1'b0, 32'h0);
    inhibit <= 1'b0;
    wait_take(1'b1, 32'h80000320);
    req <= 6'h03;
    repeat (5) @(posedge mclk_i);
    apb(1'b0, vis_pkg::OFF_CAUSE, 32'h0);
    chk({26'h0, rd[15:10]}, 32'h9);
    exc <= 1'b1;
    @(posedge mclk_i);
    exc <= 1'b0;
    apb(1'b0, vis_pkg::OFF_CAUSE, 32'h0);
    chk({26'h0, rd[15:10]}, 32'h3);
    req <= 6'h00;
    repeat (5) @(posedge mclk_i);
    ret_pulse();
    apb(1'b1, vis_pkg::OFF_CAUSE, 32'h00800300);
    evt <= 1'b1;
    wait_take(1'b0, 32'h0);
    chk({30'h0, sw_irq}, 32'h3);
    chk({30'h0, pci, debugchan_pending}, 32'h3);
    apb(1'b0, vis_pkg::OFF_CAUSE, 32'h0);
    chk(rd & 32'h44200000, 32'h44200000);
    evt <= 1'b0;
    $display("external test done");
  endtask : t_ext

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_regs();
    t_legacy();
    t_vect();
    t_ext();
    results();
  end
endmodule : vis_top_tb

bind vis_top vis_top_props i_props (.mclk_i, .resetn_i, .pready, .pslverr, .inhibit_i,
  .timer_evt_i, .take_o, .vector_o, .exception_code_o, .mode_o, .timer_irq_o);
